// File: verilog/host_spi_defs.svh
`ifndef HOST_SPI_DEFS_SVH
`define HOST_SPI_DEFS_SVH
`define IF_UART 2'h0
`define IF_SPI 2'h1
`define IF_TWO_WIRE 2'h2
`define IF_TWO_WIRE_LP 2'h3
`define FIFO_DATA_ADDR 7'h05
`define ADDR_DIR_BIT 0
`define MAX_BIT_RATE_KBPS 10000
`define CLK_RATE_KHZ 50000
`define CLK_PER_BIT (`CLK_RATE_KHZ / `MAX_BIT_RATE_KBPS)
`endif

// File: verilog/host_spi_pkg.sv
package host_spi_pkg;
	typedef struct packed {
		logic [6:0] addr;
		logic [7:0] data;
	} reg_wr_t;
	typedef enum logic [1:0] {
		ph_addr,
		ph_read,
		ph_write
	} phase_t;
endpackage

// File: verilog/wr_buffer.sv
`timescale 1ns/1ps
// two-entry buffer for outgoing register writes
module wr_buffer #(
	parameter int WIDTH = 15
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem_ff [2];
	logic rd_ff;
	logic wr_ff;
	logic [1:0] cnt_ff;
	wire push = in_valid && in_ready;
	wire pop = out_valid && out_ready;

	// occupancy gives honest full and empty
	assign in_ready = cnt_ff != 2'h2;
	assign out_valid = cnt_ff != 2'h0;
	assign out_data = mem_ff[rd_ff];

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_ff <= 1'b0;
			wr_ff <= 1'b0;
			cnt_ff <= 2'h0;
		end else begin
			if (push) wr_ff <= ~wr_ff;
			if (pop) rd_ff <= ~rd_ff;
			cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
		end
	end

	// storage needs no reset, valid gates it
	always_ff @(posedge clk) begin
		if (push) mem_ff[wr_ff] <= in_data;
	end
endmodule

// File: verilog/host_spi_slave_port.sv
`timescale 1ns/1ps
`include "host_spi_defs.svh"
module host_spi_slave_port (
	// core clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// power-up or resume from power-down, one-cycle pulse
	input wire logic wake_pulse,
	// strap pins
	input wire logic host_if_strap_lo,
	input wire logic host_if_strap_hi,
	output logic [1:0] host_if_type,
	output logic if_detect_done,
	// serial pins: a=mosi, b=sck, c=miso, d=nss
	input wire logic host_pin_a,
	input wire logic host_pin_b,
	output logic host_pin_c,
	output logic host_pin_c_oe,
	input wire logic host_pin_d,
	// register read port
	output logic rd_req,
	output logic [6:0] rd_addr,
	input wire logic [7:0] rd_data,
	// register write port
	output logic wr_valid,
	input wire logic wr_ready,
	output logic [6:0] wr_addr,
	output logic [7:0] wr_data,
	// stalled write lost flag
	output logic wr_overrun
);
	////////////////////////////////////////////////////////////////////////
	// strap detection
	logic [1:0] type_ff;
	logic done_ff;
	logic pend_ff;

	// straps are caught in a clocked step after release, never by the reset itself
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_ff <= 1'b1;
			done_ff <= 1'b0;
			type_ff <= `IF_UART;
		end else if (wake_pulse) begin
			pend_ff <= 1'b1;
			done_ff <= 1'b0;
		end else if (pend_ff) begin
			pend_ff <= 1'b0;
			done_ff <= 1'b1;
			// the high strap alone picks serial, the low strap alone picks two-wire
			type_ff <= {host_if_strap_lo, host_if_strap_hi};
		end
	end
	assign host_if_type = type_ff;
	assign if_detect_done = done_ff;
	wire spi_on = done_ff && (type_ff == `IF_SPI);
	wire port_rst = wake_pulse || !spi_on;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers, two flops each
	logic [2:0] s1_ff;
	logic [2:0] s2_ff;
	logic sck_d_ff;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_ff <= 3'h1;
			s2_ff <= 3'h1;
			sck_d_ff <= 1'b0;
		end else begin
			s1_ff <= {host_pin_a, host_pin_b, host_pin_d};
			s2_ff <= s1_ff;
			sck_d_ff <= s2_ff[1];
		end
	end
	wire mosi_s = s2_ff[2];
	wire sck_s = s2_ff[1];
	wire nss_s = s2_ff[0];
	// 160 ns sck at 20 ns clk leaves 4 samples per phase; 10 Mbit/s needs 
	// a faster core clock, see CLK_PER_BIT
	wire sck_rise = sck_s && !sck_d_ff;
	wire sck_fall = !sck_s && sck_d_ff;
	wire idle = nss_s || port_rst;

	////////////////////////////////////////////////////////////////////////
	// shifter and transaction state
	logic [2:0] bit_ff;
	logic [7:0] sh_ff;
	logic [7:0] tx_ff;
	logic [7:0] load_ff;
	logic load_pend_ff;
	logic [6:0] addr_ff;
	logic miso_ff;
	logic rd_req_ff;
	logic [6:0] rd_addr_ff;
	logic ovr_ff;
	host_spi_pkg::phase_t ph_ff;

	wire [7:0] byte_in = {sh_ff[6:0], mosi_s};
	wire byte_done = sck_rise && (bit_ff == 3'h7);
	wire is_read = byte_in[`ADDR_DIR_BIT];
	wire [6:0] byte_addr = byte_in[7:1];
	wire fifo_hit = addr_ff == `FIFO_DATA_ADDR;
	wire [6:0] addr_inc = fifo_hit ? addr_ff : addr_ff + 7'h01;
	wire do_write = byte_done && (ph_ff == host_spi_pkg::ph_write);
	wire new_addr = byte_done && (ph_ff != host_spi_pkg::ph_write);

	host_spi_pkg::reg_wr_t wr_in;
	host_spi_pkg::reg_wr_t wr_out;
	logic buf_ready;
	assign wr_in.addr = addr_ff;
	assign wr_in.data = byte_in;

	// bit counter and shift register, cleared whenever select is high
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bit_ff <= 3'h0;
			sh_ff <= 8'h00;
		end else if (idle) begin
			bit_ff <= 3'h0;
			sh_ff <= 8'h00;
		end else if (sck_rise) begin
			bit_ff <= bit_ff + 3'h1;
			sh_ff <= byte_in;
		end
	end

	// phase: address, then read answers or write data
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ph_ff <= host_spi_pkg::ph_addr;
			addr_ff <= 7'h00;
		end else if (idle) begin
			ph_ff <= host_spi_pkg::ph_addr;
		end else if (byte_done) begin
			case (ph_ff)
				host_spi_pkg::ph_addr: begin
					addr_ff <= byte_addr;
					ph_ff <= is_read ? host_spi_pkg::ph_read : host_spi_pkg::ph_write;
				end
				host_spi_pkg::ph_read: begin
					addr_ff <= byte_addr;
				end
				host_spi_pkg::ph_write: begin
					addr_ff <= addr_inc;
				end
				default: begin
					ph_ff <= host_spi_pkg::ph_addr;
				end
			endcase
		end
	end

	// read request one cycle after each address byte with the read bit set; data held for the next byte
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_req_ff <= 1'b0;
			rd_addr_ff <= 7'h00;
			load_pend_ff <= 1'b0;
			load_ff <= 8'h00;
		end else begin
			rd_req_ff <= new_addr && is_read && !idle;
			if (new_addr) rd_addr_ff <= byte_addr;
			if (idle) begin
				load_pend_ff <= 1'b0;
				load_ff <= 8'h00;
			end else if (rd_req_ff) begin
				load_pend_ff <= 1'b1;
				load_ff <= rd_data;
			end else if (do_write) begin
				load_ff <= 8'h00;
			end
			if (!idle && sck_fall && bit_ff == 3'h0) load_pend_ff <= 1'b0;
		end
	end
	assign rd_req = rd_req_ff;
	assign rd_addr = rd_addr_ff;

	// output shifter moves on falling edges, msb first
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_ff <= 8'h00;
			miso_ff <= 1'b0;
		end else if (idle) begin
			tx_ff <= 8'h00;
			miso_ff <= 1'b0;
		end else if (sck_fall) begin
			if (bit_ff == 3'h0) begin
				miso_ff <= load_ff[7];
				tx_ff <= {load_ff[6:0], 1'b0};
			end else begin
				miso_ff <= tx_ff[7];
				tx_ff <= {tx_ff[6:0], 1'b0};
			end
		end
	end
	// only drive the answer line while selected, so other slaves may share it
	assign host_pin_c = miso_ff;
	assign host_pin_c_oe = !idle;

	////////////////////////////////////////////////////////////////////////
	// write path through the two-entry buffer
	wr_buffer #(
		.WIDTH(15)
	) u_wr_buffer (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(do_write),
		.in_ready(buf_ready),
		.in_data(wr_in),
		.out_valid(wr_valid),
		.out_ready(wr_ready),
		.out_data(wr_out)
	);
	assign wr_addr = wr_out.addr;
	assign wr_data = wr_out.data;

	// sticky flag for a byte dropped against a full buffer; cleared on wake, but a drop in the same cycle wins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) ovr_ff <= 1'b0;
		else if (do_write && !buf_ready) ovr_ff <= 1'b1;
		else if (wake_pulse) ovr_ff <= 1'b0;
	end
	assign wr_overrun = ovr_ff;
endmodule

// File: verification/host_spi_slave_port_checker.sv
`timescale 1ns/1ps
// pin and handshake checker for the host serial port
module host_spi_slave_port_checker (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// strap detection
	input wire logic wake_pulse,
	input wire logic host_if_strap_lo,
	input wire logic host_if_strap_hi,
	input wire logic [1:0] host_if_type,
	input wire logic if_detect_done,
	// serial pins
	input wire logic host_pin_b,
	input wire logic host_pin_c,
	input wire logic host_pin_c_oe,
	input wire logic host_pin_d,
	// register ports
	input wire logic rd_req,
	input wire logic wr_valid,
	input wire logic wr_ready,
	input wire logic [6:0] wr_addr,
	input wire logic [7:0] wr_data
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_type_straps: assert property ($rose(if_detect_done) |->
		host_if_type == {host_if_strap_lo, host_if_strap_hi}) else $error("type not straps");
	a_wake_redetect: assert property (wake_pulse |-> ##[1:4] if_detect_done)
		else $error("no detection after wake");
	a_oe_spi_only: assert property (host_pin_c_oe |-> host_if_type == 2'h1)
		else $error("miso driven off serial mode");
	a_oe_idle_off: assert property (host_pin_d [*4] |-> !host_pin_c_oe)
		else $error("miso driven while deselected");
	a_no_read_idle: assert property (host_pin_d [*4] |-> !rd_req)
		else $error("read while deselected");
	// miso moves three cycles after a fall, so it must sit still while the clock is high
	a_miso_hold: assert property (host_pin_b [*2] |-> $stable(host_pin_c))
		else $error("miso moved with clock high");
	a_rd_pulse: assert property (rd_req |=> !rd_req)
		else $error("read request too long");
	a_wr_hold: assert property (wr_valid && !wr_ready && !wake_pulse |=>
		wr_valid && $stable({wr_addr, wr_data})) else $error("write entry changed");
endmodule
bind host_spi_slave_port host_spi_slave_port_checker i_chk (.*);

// File: verification/spi_host_model.sv
`timescale 1ns/1ps
// serial master paced by the core clock: 160 ns serial period
module spi_host_model (
	// pacing clock
	input wire logic clk,
	// serial pins
	output logic sck,
	output logic mosi,
	output logic nss_n,
	input wire logic miso
);
	initial begin
		sck = 1'b0;
		mosi = 1'b0;
		nss_n = 1'b1;
	end
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
	endtask
	// msb first; mosi moves only with sck low, miso taken at the rise
	task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
		for (int i = 7; i >= 8 - n; i--) begin
			mosi <= tx[i];
			wt(4);
			sck <= 1'b1;
			rx[i] = miso;
			wt(4);
			sck <= 1'b0;
		end
	endtask
	// a released mosi flips so a stale bit never looks valid
	task automatic sel(input bit on);
		wt(4);
		nss_n <= !on;
		if (!on) mosi <= ~mosi;
		wt(4);
	endtask
endmodule

// File: verification/host_spi_slave_port_tb_top.sv
`timescale 1ns/1ps
`include "host_spi_defs.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_total++; \
	$display("wrong value at %0t: %h %h", $time, g, e); end end
module host_spi_slave_port_tb_top;
	logic clk = 0, rst_n = 0, wake_pulse, wr_ready;
	logic host_if_strap_lo, host_if_strap_hi;
	logic host_pin_a, host_pin_b, host_pin_c, host_pin_c_oe, host_pin_d;
	logic if_detect_done, rd_req, wr_valid, wr_overrun;
	logic [1:0] host_if_type;
	logic [6:0] rd_addr, wr_addr;
	logic [7:0] rd_data, wr_data, rx;
	logic [14:0] wq[$];
	int err_total = 0, n_tests = 0;
	// register stand-in: pure function of the address, nothing to go stale
	assign rd_data = {rd_addr, 1'b1} ^ 8'h5A;
	always #10 clk = ~clk;
	host_spi_slave_port i_dut (.*);
	spi_host_model u_host (.clk(clk), .sck(host_pin_b), .mosi(host_pin_a),
		.nss_n(host_pin_d), .miso(host_pin_c));
	// collect every accepted write
	always @(posedge clk) begin
		if (wr_valid === 1'b1 && wr_ready === 1'b1) wq.push_back({wr_addr, wr_data});
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic wake;
		@(posedge clk) wake_pulse <= 1'b1;
		@(posedge clk) wake_pulse <= 1'b0;
		repeat (4) @(posedge clk);
	endtask
	// every strap code in turn, ending on the serial port
	task automatic t_straps;
		logic [1:0] k;
		logic [1:0] ex;
		for (int j = 0; j < 4; j++) begin
			k = 2'(j + 3);
			{host_if_strap_hi, host_if_strap_lo} <= k;
			wake();
			ex = (k == 2'h0) ? `IF_UART : (k == 2'h2) ? `IF_SPI :
				(k == 2'h1) ? `IF_TWO_WIRE : `IF_TWO_WIRE_LP;
			`CHK(host_if_type, ex)
		end
		$display("test straps done");
	endtask
	// write burst; a stalled sink keeps two words and loses the third
	task automatic t_write(input logic [6:0] a, input int n, input bit stall);
		int m;
		m = stall ? 2 : n;
		wq.delete();
		wr_ready <= !stall;
		u_host.sel(1);
		u_host.xfer({a, 1'b0}, 8, rx);
		for (int i = 0; i < n; i++) u_host.xfer(8'hA0 + 8'(i), 8, rx);
		u_host.sel(0);
		if (stall) begin
			`CHK(wr_overrun, 1'b1)
			wr_ready <= 1'b1;
		end
		for (int t = 0; t < 50 && wq.size() < m; t++) @(posedge clk);
		if (wq.size() != m) begin
			err_total++;
			finish_test();
		end
		for (int i = 0; i < m; i++) begin
			`CHK(wq[i], {a + 7'(a == `FIFO_DATA_ADDR ? 0 : i), 8'hA0 + 8'(i)})
		end
		if (stall) begin
			wake();
			`CHK(wr_overrun, 1'b0)
		end
		$display("test write done");
	endtask
	// two reads back to back; each answer comes in the following byte
	task automatic t_read;
		u_host.sel(1);
		u_host.xfer({7'h21, 1'b1}, 8, rx);
		`CHK(host_pin_c_oe, 1'b1)
		u_host.xfer({7'h33, 1'b1}, 8, rx);
		`CHK(rx, 8'h43 ^ 8'h5A)
		u_host.xfer(8'h00, 8, rx);
		`CHK(rx, 8'h67 ^ 8'h5A)
		u_host.sel(0);
		`CHK(host_pin_c_oe, 1'b0)
		$display("test read done");
	endtask
	initial begin
		wake_pulse <= 1'b0;
		wr_ready <= 1'b1;
		host_if_strap_lo <= 1'b0;
		host_if_strap_hi <= 1'b1;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		`CHK(if_detect_done, 1'b1)
		`CHK(host_if_type, 2'h1)
		t_straps();
		t_write(7'h10, 3, 0);
		t_write(`FIFO_DATA_ADDR, 3, 1);
		t_read();
		// half a byte then deselect: the next frame must start with an address
		u_host.sel(1);
		u_host.xfer(8'hFF, 4, rx);
		u_host.sel(0);
		t_write(7'h3C, 2, 0);
		finish_test();
	end
endmodule
